// File: design/cmcp_defines.svh
`ifndef CMCP_DEFINES_SVH
`define CMCP_DEFINES_SVH

// register indices on the three-bit port
`define CMCP_ADDR_W          3
`define CMCP_DATA_W          8
`define CMCP_REG_INPUT_PRESCALE_VALUE        3'h0
`define CMCP_REG_FEEDBACK_PRESCALE_VALUE        3'h1
`define CMCP_REG_FAST_OUTPUT_PRESCALE_VALUE        3'h2
`define CMCP_REG_DUTY        3'h3
`define CMCP_REG_OSC_RANGE   3'h4
`define CMCP_REG_MODE        3'h5
`define CMCP_REG_OUTSEL      3'h6
`define CMCP_REG_CONTROL     3'h7

// control register fields
`define CMCP_CTL_ENABLE      0
`define CMCP_CTL_DLL_RST     1
`define CMCP_CTL_PLL_RST     2
`define CMCP_CTL_CFG_RUN     6
`define CMCP_CTL_GSR_BYPASS  7

// oscillator range code layout
`define CMCP_OSC_MODE_HI     7
`define CMCP_OSC_MODE_LO     6
`define CMCP_OSC_FINE_HI     2
`define CMCP_OSC_COARSE_LO   3
`define CMCP_OSC_COARSE_OFS  5'h10
`define CMCP_OSC_UPPER_OFS   5'h08

// sequencing times in microseconds, rate in MHz
`define CMCP_CLK_MHZ         250
`define CMCP_WAKE_US         10
`define CMCP_SHUT_US         10
`define CMCP_ACQ_US          100

`endif

// File: design/cmcp_device.sv
`timescale 1ns/1ps
`include "cmcp_defines.svh"

// Function
// - fabric sets address, then raises read strobe
// - address change during read returns new register
// - read data released while strobe low
// - fabric drives data and address, then writes
// - write captured on rising write strobe
// - read and write never together
// - lock high when clock within spec
// - lock may dip one or two cycles
// - lock may toggle during acquisition
// - fabric should integrate lock before trusting
// - control bit 0 enables, clear powers off
// - control bits 1 and 2 reset dll and pll
// - function resets leave all registers intact
// - control bit 7 masks chip-wide reset
// - bit 6 set: run during configuration
// - bit 6 clear: off until configuration done
// - initial settings loadable from bit stream
// - enable: wake, acquire, then steady state
// - disable: shutdown interval follows
// - oscillator range code decodes to step
// - three fastest range codes not recommended
// - pick range nearest desired frequency
module cmcp_device
  import cmcp_pkg::*;
#(
  parameter int                      WAKE_CYCLES = `CMCP_WAKE_US * `CMCP_CLK_MHZ,
  parameter int                      SHUT_CYCLES = `CMCP_SHUT_US * `CMCP_CLK_MHZ,
  parameter int                      ACQ_CYCLES  = `CMCP_ACQ_US * `CMCP_CLK_MHZ,
  parameter logic [`CMCP_DATA_W-1:0] INIT_INPUT_PRESCALE_VALUE   = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_FEEDBACK_PRESCALE_VALUE   = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_FAST_OUTPUT_PRESCALE_VALUE   = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_DUTY   = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_OSC    = 8'hff,
  parameter logic [`CMCP_DATA_W-1:0] INIT_MODE   = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_OUTSEL = 8'h00,
  parameter logic [`CMCP_DATA_W-1:0] INIT_CTRL   = 8'h00
) (
  // clock and resets
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         chipWideReset_n,
  input  wire logic         configDone,
  // register port toward the fabric
  cmcp_port_if.device       port,
  // analog core view
  input  wire logic         clockInSpec,
  output logic              analogPowerOn,
  output logic              dllReset,
  output logic              pllReset,
  output logic [4:0]        oscStep,
  output logic              managerRunning
);
  // ****************
  // parameter check
  // ****************
  if (WAKE_CYCLES < 1 || SHUT_CYCLES < 1 || ACQ_CYCLES < 1) begin : gBadCounts
    $error("cmcp_device: interval counts must be at least one");
  end

  localparam int CW = $clog2(ACQ_CYCLES + WAKE_CYCLES + SHUT_CYCLES + 1);

  // ****************
  // pin synchronisers
  // ****************
  logic [15:0] pins;
  logic [15:0] pinsSync;
  logic [7:0] dataS;
  logic [2:0] addrS;
  logic       readS;
  logic       writeS;
  logic       gsrnS;
  logic       doneS;
  logic       inSpecS;

  cmcp_sync #(.WIDTH(16)) uSync (
    .clock  (clock),
    .reset  (reset),
    .async  (pins),
    .synced (pinsSync)
  );
  assign pins = {clockInSpec, configDone, chipWideReset_n, port.writeStrobe,
                 port.readStrobe, port.address, port.writeData};
  assign {inSpecS, doneS, gsrnS, writeS, readS, addrS, dataS} = pinsSync;

  // ****************
  // register file
  // ****************
  // write data rides the same synchroniser; it settles before the synced
  // strobe edge, so no bit is caught mid-change
  logic [7:0] regs_q [8];
  logic [7:0] regs_d [8];
  logic       writeOld_q;
  logic [7:0] readData_q;
  logic [7:0] readData_d;
  logic       readOe_q;

  always_comb begin
    regs_d = regs_q;
    if (writeS && !writeOld_q && !readS)
      regs_d[addrS] = dataS;
    // function resets touch no register contents
    readData_d = regs_q[addrS];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // power-on image from the bit stream
      regs_q[`CMCP_REG_INPUT_PRESCALE_VALUE]      <= INIT_INPUT_PRESCALE_VALUE;
      regs_q[`CMCP_REG_FEEDBACK_PRESCALE_VALUE]      <= INIT_FEEDBACK_PRESCALE_VALUE;
      regs_q[`CMCP_REG_FAST_OUTPUT_PRESCALE_VALUE]      <= INIT_FAST_OUTPUT_PRESCALE_VALUE;
      regs_q[`CMCP_REG_DUTY]      <= INIT_DUTY;
      regs_q[`CMCP_REG_OSC_RANGE] <= INIT_OSC;
      regs_q[`CMCP_REG_MODE]      <= INIT_MODE;
      regs_q[`CMCP_REG_OUTSEL]    <= INIT_OUTSEL;
      regs_q[`CMCP_REG_CONTROL]   <= INIT_CTRL;
      writeOld_q <= 1'b0;
      readData_q <= 8'h00;
      readOe_q   <= 1'b0;
    end else begin
      regs_q     <= regs_d;
      writeOld_q <= writeS;
      readData_q <= readData_d;
      readOe_q   <= readS;
    end
  end

  assign port.readDataOut  = readData_q;
  assign port.readDataOe_n = !readOe_q;

  // ****************
  // oscillator range decode
  // ****************
  logic [7:0] osc;
  assign osc = regs_q[`CMCP_REG_OSC_RANGE];
  always_comb begin
    if (!osc[`CMCP_OSC_MODE_HI])
      oscStep = {1'b0, osc[`CMCP_OSC_MODE_LO], osc[`CMCP_OSC_FINE_HI:0]};
    else
      oscStep = osc[`CMCP_OSC_MODE_HI:`CMCP_OSC_COARSE_LO];
  end

  // ****************
  // power sequencer
  // ****************
  logic [7:0] ctrl;
  logic       held;
  logic       wantOn;
  assign ctrl   = regs_q[`CMCP_REG_CONTROL];
  // chip-wide reset only reaches the manager when not bypassed
  assign held   = !gsrnS && !ctrl[`CMCP_CTL_GSR_BYPASS];
  assign wantOn = ctrl[`CMCP_CTL_ENABLE] && !held
                  && (doneS || ctrl[`CMCP_CTL_CFG_RUN]);

  cmcp_state_type state_q;
  cmcp_state_type state_d;
  logic [CW-1:0]  count_q;
  logic [CW-1:0]  count_d;
  logic           lock_q;
  logic           lock_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q + 1'b1;
    lock_d  = 1'b0;
    case (state_q)
      CMCP_OFF: begin
        count_d = '0;
        if (wantOn)
          state_d = CMCP_WAKE;
      end
      CMCP_WAKE: begin
        if (!wantOn) begin
          state_d = CMCP_SHUT;
          count_d = '0;
        end else if (count_q >= CW'(WAKE_CYCLES - 1)) begin
          state_d = CMCP_ACQ;
          count_d = '0;
        end
      end
      CMCP_ACQ: begin
        lock_d = inSpecS;
        if (!wantOn) begin
          state_d = CMCP_SHUT;
          count_d = '0;
        end else if (count_q >= CW'(ACQ_CYCLES - 1)) begin
          state_d = CMCP_LOCK;
          count_d = '0;
        end
      end
      CMCP_LOCK: begin
        count_d = '0;
        // short dips follow the core's own corrections
        lock_d  = inSpecS;
        if (!wantOn)
          state_d = CMCP_SHUT;
      end
      CMCP_SHUT: begin
        if (count_q >= CW'(SHUT_CYCLES - 1)) begin
          state_d = CMCP_OFF;
          count_d = '0;
        end
      end
      default: begin
        state_d = CMCP_OFF;
        count_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= CMCP_OFF;
      count_q <= '0;
      lock_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      lock_q  <= lock_d;
    end
  end

  assign port.lock      = lock_q;
  assign analogPowerOn  = (state_q != CMCP_OFF);
  assign managerRunning = (state_q == CMCP_ACQ) || (state_q == CMCP_LOCK);
  // dll and pll logic reset by their bits, by unbypassed chip-wide reset, or while the manager is not running (off, wake, shutdown)
  assign dllReset = ctrl[`CMCP_CTL_DLL_RST] || held || !managerRunning;
  assign pllReset = ctrl[`CMCP_CTL_PLL_RST] || held || !managerRunning;
endmodule

// File: design/cmcp_fabric.sv
`timescale 1ns/1ps
`include "cmcp_defines.svh"

module cmcp_fabric
  import cmcp_pkg::*;
#(
  parameter int LOCK_FILTER = 16,
  parameter int STEP_CYCLES = 4
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // user request
  input  wire logic       reqValid,
  input  wire logic       reqWrite,
  input  wire logic [2:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            reqReady,
  output logic [7:0]      rspData,
  output logic            rspValid,
  output logic            lockStable,
  // register port toward the manager
  cmcp_port_if.fabric     port
);
  // the manager needs two sync stages and a register stage before it drives data
  if (LOCK_FILTER < 1 || STEP_CYCLES < 4) begin : gBadParams
    $error("cmcp_fabric: bad parameter");
  end

  // ****************
  // strobe sequencer
  // ****************
  localparam int SW = $clog2(STEP_CYCLES + 2);
  logic [SW-1:0] step_q, step_d;
  logic          busy_q, busy_d, write_q, write_d;
  logic [2:0]    addr_q, addr_d;
  logic [7:0]    data_q, data_d, rsp_q, rsp_d;
  logic          rspV_q, rspV_d;
  logic          lockS;
  logic          lockSync;
  logic          strobeOn;

  always_comb begin
    step_d = step_q;
    busy_d = busy_q;
    write_d = write_q;
    addr_d = addr_q;
    data_d = data_q;
    rsp_d  = rsp_q;
    rspV_d = 1'b0;
    if (!busy_q) begin
      if (reqValid) begin
        busy_d  = 1'b1;
        write_d = reqWrite;
        addr_d  = reqAddr;
        data_d  = reqData;
        step_d  = '0;
      end
    end else begin
      step_d = step_q + 1'b1;
      // take read data on the last strobe-high step, once the bus is driven
      if (step_q == SW'(STEP_CYCLES)) begin
        rspV_d = !write_q;
        rsp_d  = port.readDataOut;
      end
      // one low step while busy keeps three low cycles between strobes
      if (step_q == SW'(STEP_CYCLES + 1))
        busy_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      step_q <= '0;
      busy_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      rsp_q  <= '0;
      rspV_q <= 1'b0;
    end else begin
      step_q <= step_d;
      busy_q <= busy_d;
      write_q <= write_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rsp_q  <= rsp_d;
      rspV_q <= rspV_d;
    end
  end

  // address and data settle one step before any strobe
  assign port.address     = addr_q;
  assign port.writeData   = data_q;
  assign strobeOn = busy_q && step_q != '0 && step_q <= SW'(STEP_CYCLES);
  assign port.readStrobe  = strobeOn && !write_q;
  assign port.writeStrobe = strobeOn && write_q;
  assign reqReady = !busy_q;
  assign rspData  = rsp_q;
  assign rspValid = rspV_q;

  // ****************
  // lock integrator
  // ****************
  cmcp_sync #(.WIDTH(1)) uLockSync (
    .clock  (clock),
    .reset  (reset),
    .async  (lockS),
    .synced (lockSync)
  );
  assign lockS = port.lock;

  localparam int LW = $clog2(LOCK_FILTER + 1);
  logic [LW-1:0] lcnt_q, lcnt_d;
  always_comb begin
    if (!lockSync)
      lcnt_d = '0;
    else if (lcnt_q != LW'(LOCK_FILTER))
      lcnt_d = lcnt_q + 1'b1;
    else
      lcnt_d = lcnt_q;
  end
  always_ff @(posedge clock) begin
    if (reset)
      lcnt_q <= '0;
    else
      lcnt_q <= lcnt_d;
  end
  assign lockStable = (lcnt_q == LW'(LOCK_FILTER));
endmodule

// File: design/cmcp_pkg.sv
package cmcp_pkg;
  typedef enum logic [4:0] {
    CMCP_OFF   = 5'b00001,
    CMCP_WAKE  = 5'b00010,
    CMCP_ACQ   = 5'b00100,
    CMCP_LOCK  = 5'b01000,
    CMCP_SHUT  = 5'b10000
  } cmcp_state_type;
endpackage

// File: design/cmcp_port_if.sv
`timescale 1ns/1ps
interface cmcp_port_if;
  logic [2:0] address;
  logic       readStrobe;
  logic       writeStrobe;
  logic [7:0] writeData;
  logic [7:0] readDataOut;
  logic       readDataOe_n;
  logic       lock;

  modport device (
    input  address, readStrobe, writeStrobe, writeData,
    output readDataOut, readDataOe_n, lock
  );
  modport fabric (
    output address, readStrobe, writeStrobe, writeData,
    input  readDataOut, readDataOe_n, lock
  );
endinterface

// File: design/cmcp_sync.sv
`timescale 1ns/1ps
module cmcp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] synced_d;

  always_comb begin
    meta_d   = async;
    synced_d = meta_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= meta_d;
      synced <= synced_d;
    end
  end
endmodule

// File: dv/cmcp_port_properties.sv
`timescale 1ns/1ps
// ****************
// port handshake checks
// ****************
module cmcp_port_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // register port
  input wire logic [2:0] address,
  input wire logic       readStrobe,
  input wire logic       writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic       readDataOe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_bus_released: assert property (!readStrobe [*5] |-> readDataOe_n)
    else $error("read bus still driven while idle");
  a_bus_held: assert property ($fell(readStrobe) |-> !readDataOe_n)
    else $error("read data dropped as strobe fell");
  a_no_overlap: assert property (!(readStrobe && writeStrobe))
    else $error("read and write strobes together");
  a_rd_high: assert property ($rose(readStrobe) |-> readStrobe [*3])
    else $error("read strobe too short");
  a_rd_low: assert property ($fell(readStrobe) |-> !readStrobe [*3])
    else $error("read strobe gap too short");
  a_wr_high: assert property ($rose(writeStrobe) |-> writeStrobe [*3])
    else $error("write strobe too short");
  a_wr_low: assert property ($fell(writeStrobe) |-> !writeStrobe [*3])
    else $error("write strobe gap too short");
  a_wr_steady: assert property (writeStrobe && $past(writeStrobe)
      |-> $stable(address) && $stable(writeData))
    else $error("write address or data moved");
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cmcp_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        chipWideReset_n = 1'b1;
  logic        configDone = 1'b0;
  logic        clockInSpec = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [2:0]  reqAddr = 3'h0;
  logic [7:0]  reqData = 8'h00;
  logic        reqReady, rspValid, lockStable;
  logic [7:0]  rspData;
  logic        analogPowerOn, dllReset, pllReset, managerRunning;
  logic [4:0]  oscStep;
  logic [15:0] status;
  int          failCount = 0;
  int          checksDone = 0;
  int          cycles = 0;
  // the three fastest codes stay unused; codes span the bands
  logic [7:0]  codes [4] = '{8'h3d, 8'h47, 8'h80, 8'hff};
  logic [15:0] steps [4] = '{16'h0005, 16'h000f, 16'h0010, 16'h001f};
  localparam logic [15:0] OSC = 16'h001f, LCK = 16'h0020, PLL = 16'h0040;
  localparam logic [15:0] DLL = 16'h0080, RUN = 16'h0100, PWR = 16'h0200;

  assign status = {6'h00, analogPowerOn, managerRunning, dllReset, pllReset, lockStable, oscStep};
  always #2 clock = ~clock;

  cmcp_port_if cmcp_port_if_i ();
  cmcp_device #(.WAKE_CYCLES(4), .SHUT_CYCLES(4), .ACQ_CYCLES(8)) cmcp_device_i (
    .clock(clock), .reset(reset), .chipWideReset_n(chipWideReset_n),
    .configDone(configDone), .port(cmcp_port_if_i), .clockInSpec(clockInSpec),
    .analogPowerOn(analogPowerOn), .dllReset(dllReset), .pllReset(pllReset),
    .oscStep(oscStep), .managerRunning(managerRunning));
  cmcp_fabric #(.LOCK_FILTER(4), .STEP_CYCLES(4)) cmcp_fabric_i (
    .clock(clock), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspData(rspData),
    .rspValid(rspValid), .lockStable(lockStable), .port(cmcp_port_if_i));
  cmcp_port_properties cmcp_port_properties_i (
    .clock(clock), .reset(reset), .address(cmcp_port_if_i.address),
    .readStrobe(cmcp_port_if_i.readStrobe), .writeStrobe(cmcp_port_if_i.writeStrobe),
    .writeData(cmcp_port_if_i.writeData), .readDataOe_n(cmcp_port_if_i.readDataOe_n));

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check("request ready", 16'h0001, {15'h0000, reqReady});
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    tick(1);
    reqValid = 1'b0;
  endtask

  task automatic readReg(input logic [2:0] a, input logic [7:0] exp);
    int n;
    access(1'b0, a, 8'h00);
    n = 0;
    while (rspValid !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check("read valid", 16'h0001, {15'h0000, rspValid});
    check("read data", {8'h00, exp}, {8'h00, rspData});
  endtask

  // bounded poll; long waits cover wake plus acquisition
  task automatic waitStat(input string what, input logic [15:0] m, input logic [15:0] exp);
    int n;
    n = 0;
    while ((status & m) !== exp && n < 60) begin
      tick(1);
      n++;
    end
    check(what, exp, status & m);
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      finishTest();
    end
  end

  initial begin
    tick(5);
    reset = 1'b0;
    readReg(3'h4, 8'hff);
    readReg(3'h7, 8'h00);
    waitStat("step", OSC, 16'h001f);
    $display("test reset done");
    for (int a = 0; a < 7; a++) access(1'b1, a[2:0], 8'h30 + a[7:0]);
    for (int a = 0; a < 7; a++) readReg(a[2:0], 8'h30 + a[7:0]);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 3'h4, codes[i]);
      waitStat("step", OSC, steps[i]);
      readReg(3'h4, codes[i]);
    end
    $display("test range done");
    clockInSpec = 1'b1;
    access(1'b1, 3'h7, 8'h01);
    tick(20);
    check("held off", 16'h0000, status & PWR);
    configDone = 1'b1;
    waitStat("running", PWR | RUN, PWR | RUN);
    waitStat("lock", LCK, LCK);
    clockInSpec = 1'b0;
    waitStat("lock lost", LCK, 16'h0000);
    clockInSpec = 1'b1;
    access(1'b1, 3'h7, 8'h03);
    waitStat("dll only", DLL | PLL, DLL);
    access(1'b1, 3'h7, 8'h07);
    waitStat("resets", DLL | PLL, DLL | PLL);
    readReg(3'h4, 8'hff);
    readReg(3'h7, 8'h07);
    $display("test sequencing done");
    access(1'b1, 3'h7, 8'h81);
    waitStat("running", RUN, RUN);
    chipWideReset_n = 1'b0;
    tick(20);
    check("bypass", RUN, status & RUN);
    chipWideReset_n = 1'b1;
    access(1'b1, 3'h7, 8'h01);
    chipWideReset_n = 1'b0;
    waitStat("chip reset", RUN, 16'h0000);
    chipWideReset_n = 1'b1;
    access(1'b1, 3'h7, 8'h01);
    waitStat("running", RUN, RUN);
    // power must outlast the running flag: shutdown keeps the supply up
    access(1'b1, 3'h7, 8'h00);
    waitStat("stopping", RUN, 16'h0000);
    check("shutdown power", PWR, status & PWR);
    waitStat("off", PWR, 16'h0000);
    configDone = 1'b0;
    access(1'b1, 3'h7, 8'h41);
    waitStat("config run", PWR, PWR);
    $display("test control done");
    finishTest();
  end
endmodule
